// ==== logic/uvep_pkg.sv ====
// Purpose: constants for the eprom programming loop controller
// Assumes: 100 MHz clk, synchronous active-high reset
// Notes:   pulse and setup times held in ns and converted to cycles
package uvep_pkg;
  localparam int unsigned CLK_PERIOD_NS   = 10;
  localparam int unsigned ADDR_W          = 10;
  localparam int unsigned DATA_W          = 8;
  localparam int unsigned WORDS_SMALL     = 512;
  localparam int unsigned WORDS_LARGE     = 1024;
  localparam int unsigned PULSE_MIN_NS    = 100000;
  localparam int unsigned PULSE_MAX_NS    = 1000000;
  localparam int unsigned TOTAL_MIN_NS    = 100000000;
  localparam int unsigned LOOPS_AT_MAX    = 100;
  localparam int unsigned LOOPS_AT_MIN    = 1000;
  // short setup and hold; slow boards may need these raised
  localparam int unsigned SETUP_NS        = 100;
  localparam int unsigned HOLD_NS         = 100;
  localparam int unsigned MODE_NS         = 10000;
  // default pulse width and derived cycle counts
  localparam int unsigned PULSE_NS        = 1000000;
  localparam int unsigned PULSE_CYC       = PULSE_NS / CLK_PERIOD_NS;
  localparam int unsigned SETUP_CYC       =
    (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned HOLD_CYC        =
    (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned MODE_CYC        =
    (MODE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned LOOPS_DEFAULT   =
    (TOTAL_MIN_NS + PULSE_NS - 1) / PULSE_NS;
  localparam int unsigned CNT_W           = 24;
  localparam int unsigned LOOP_W          = 12;
  typedef enum {
    UVEP_IDLE, UVEP_ENTER, UVEP_SETUP, UVEP_PULSE, UVEP_HOLD,
    UVEP_EXIT, UVEP_DONE
  } uvep_state_t;
endpackage : uvep_pkg

// ==== logic/uvep_sync.sv ====
// Purpose: three-stage synchroniser with agreement filter
// Assumes: asynchronous level input
// Notes:   first stage read only by the second
module uvep_sync (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic din,
  output logic      dout
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  always_ff @(posedge clk) begin
    if (reset) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      dout <= 1'b0;
    end else if (s2_reg == s3_reg) begin
      dout <= s3_reg;
    end
  end
endmodule : uvep_sync

// ==== logic/uvep_prog.sv ====
// Purpose: programmer that writes a whole uv eprom in repeated loops
// Assumes: word data fetched from user side one word per address
// Notes:   device pins driven directly; pulse width fixed per build
module uvep_prog
  import uvep_pkg::*;
#(
  parameter int unsigned PULSE_CYCLES = PULSE_CYC,
  parameter int unsigned LOOP_COUNT   = LOOPS_DEFAULT
) (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic              start,
  input  wire logic              large_part,
  input  wire logic              abort_pin,
  output logic                   word_req,
  output logic [ADDR_W-1:0]      word_req_addr,
  input  wire logic [DATA_W-1:0] word_data,
  output logic [ADDR_W-1:0]      word_address_lines,
  output logic [DATA_W-1:0]      data_out,
  output logic                   data_oe,
  output logic                   sel_write_prog,
  output logic                   program_pulse,
  output logic                   program_pulse_oe,
  output logic                   busy,
  output logic                   done,
  output logic [LOOP_W-1:0]      loop_index
);
  uvep_state_t       state_reg;
  logic [CNT_W-1:0]  cnt_reg;
  logic [ADDR_W-1:0] last_addr_reg;
  logic              abort_s;
  logic              abort_go;
  logic              pulse_seen_reg;

  uvep_sync u_abort (
    .clk   (clk),
    .reset (reset),
    .din   (abort_pin),
    .dout  (abort_s)
  );

  function automatic logic [CNT_W-1:0] cyc(input int unsigned n);
    cyc = CNT_W'(n - 1);
  endfunction : cyc

  wire logic cnt_end = (cnt_reg == '0);
  wire logic last_word = (word_address_lines == last_addr_reg);
  wire logic last_loop = (loop_index == LOOP_W'(LOOP_COUNT - 1));
  // a pulse is never cut, and exit must be left to count down
  assign abort_go = abort_s && busy && (state_reg != UVEP_PULSE) &&
                    (state_reg != UVEP_EXIT);

  // word fetch is a combinational handshake while setting up
  assign word_req      = (state_reg == UVEP_SETUP) && cnt_end;
  assign word_req_addr = word_address_lines;
  assign busy          = (state_reg != UVEP_IDLE) &&
                         (state_reg != UVEP_DONE);
  // program pin always driven, never left to a pull-down
  assign program_pulse_oe = 1'b1;

  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= UVEP_IDLE;
    end else if (abort_go) begin
      state_reg <= UVEP_EXIT;
    end else begin
      case (state_reg)
        UVEP_IDLE:  if (start) state_reg <= UVEP_ENTER;
        UVEP_ENTER: if (cnt_end) state_reg <= UVEP_SETUP;
        UVEP_SETUP: if (cnt_end) state_reg <= UVEP_PULSE;
        UVEP_PULSE: if (cnt_end) state_reg <= UVEP_HOLD;
        UVEP_HOLD: begin
          if (cnt_end) begin
            if (last_word && last_loop) state_reg <= UVEP_EXIT;
            else state_reg <= UVEP_SETUP;
          end
        end
        UVEP_EXIT:  if (cnt_end) state_reg <= UVEP_DONE;
        UVEP_DONE:  if (!start) state_reg <= UVEP_IDLE;
        default:    state_reg <= UVEP_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_reg <= '0;
    end else if (abort_go) begin
      cnt_reg <= cyc(MODE_CYC);
    end else if (!cnt_end && state_reg != UVEP_IDLE) begin
      cnt_reg <= cnt_reg - 1'b1;
    end else begin
      case (state_reg)
        UVEP_IDLE:  cnt_reg <= cyc(MODE_CYC);
        UVEP_ENTER: cnt_reg <= cyc(SETUP_CYC);
        UVEP_SETUP: cnt_reg <= cyc(PULSE_CYCLES);
        UVEP_PULSE: cnt_reg <= cyc(HOLD_CYC);
        UVEP_HOLD:  cnt_reg <= (last_word && last_loop) ?
                               cyc(MODE_CYC) : cyc(SETUP_CYC);
        default:    cnt_reg <= cyc(MODE_CYC);
      endcase
    end
  end

  // address steps up once per pulse, wrapping to start a new loop
  always_ff @(posedge clk) begin
    if (reset) begin
      word_address_lines <= '0;
      last_addr_reg      <= ADDR_W'(WORDS_SMALL - 1);
    end else if (state_reg == UVEP_IDLE && start) begin
      word_address_lines <= '0;
      last_addr_reg <= large_part ? ADDR_W'(WORDS_LARGE - 1)
                                  : ADDR_W'(WORDS_SMALL - 1);
    end else if (state_reg == UVEP_HOLD && cnt_end && !abort_go &&
                 !(last_word && last_loop)) begin
      word_address_lines <= last_word ? '0
                          : word_address_lines + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      loop_index <= '0;
    end else if (state_reg == UVEP_IDLE && start) begin
      loop_index <= '0;
    end else if (state_reg == UVEP_HOLD && cnt_end && last_word &&
                 !last_loop && !abort_go) begin
      loop_index <= loop_index + 1'b1;
    end
  end

  // data captured at end of setup, held through pulse and hold
  always_ff @(posedge clk) begin
    if (reset) begin
      data_out <= '0;
    end else if (word_req) begin
      data_out <= word_data;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      sel_write_prog <= 1'b0;
      data_oe        <= 1'b0;
      program_pulse  <= 1'b0;
      done           <= 1'b0;
    end else begin
      sel_write_prog <= (state_reg == UVEP_ENTER) ||
                        (state_reg == UVEP_SETUP) ||
                        (state_reg == UVEP_PULSE) ||
                        (state_reg == UVEP_HOLD);
      data_oe        <= (state_reg == UVEP_SETUP && !cnt_end) ||
                        (state_reg == UVEP_PULSE) ||
                        (state_reg == UVEP_HOLD);
      program_pulse  <= (state_reg == UVEP_PULSE);
      done           <= (state_reg == UVEP_DONE);
    end
  end

  // helper for the one-pulse check: set by a pulse, cleared by a step
  always_ff @(posedge clk) begin
    if (reset || state_reg == UVEP_IDLE) begin
      pulse_seen_reg <= 1'b0;
    end else if ($changed(word_address_lines)) begin
      pulse_seen_reg <= 1'b0;
    end else if (program_pulse) begin
      pulse_seen_reg <= 1'b1;
    end
  end

  a_addr_stable: assert property (@(posedge clk) disable iff (reset)
    program_pulse |-> $stable(word_address_lines) && $stable(data_out))
    else $error("address or data moved during pulse");
  a_sel_before_addr: assert property (@(posedge clk) disable iff (reset)
    (state_reg == UVEP_EXIT || state_reg == UVEP_DONE) |->
      $stable(word_address_lines))
    else $error("address moved after leaving program mode");
  a_pulse_needs_sel: assert property (@(posedge clk) disable iff (reset)
    $rose(program_pulse) |-> sel_write_prog && data_oe)
    else $error("pulse without program level or data");
  a_pulse_width: assert property (@(posedge clk) disable iff (reset)
    $rose(program_pulse) |-> program_pulse [*8])
    else $error("program pulse too short");
  a_one_pulse: assert property (@(posedge clk) disable iff (reset)
    $rose(program_pulse) |-> !pulse_seen_reg)
    else $error("second pulse on same address");
  a_addr_wrap: assert property (@(posedge clk) disable iff (reset)
    $changed(loop_index) && loop_index != '0 |->
      word_address_lines == '0)
    else $error("loop did not restart at zero");
  a_step_one: assert property (@(posedge clk) disable iff (reset)
    $changed(word_address_lines) && word_address_lines != '0 |->
      word_address_lines == $past(word_address_lines) + 1'b1)
    else $error("address skipped a word");
  a_drive_low: assert property (@(posedge clk) disable iff (reset)
    program_pulse_oe)
    else $error("program pin not driven");
endmodule : uvep_prog

// ==== testbench/uvep_eprom_model.sv ====
// Purpose: behavioural uv eprom seen by the loop programmer
// Assumes: pulse edges sampled on clk
// Notes:   counts pulses, widths and address slips for the bench
module uvep_eprom_model
  import uvep_pkg::*;
(
  input wire logic              clk,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] data_in,
  input wire logic              sel_write,
  input wire logic              pgm,
  input wire logic              pgm_oe
);
  logic [DATA_W-1:0] mem [WORDS_LARGE];
  int                pulses [WORDS_LARGE];
  logic [ADDR_W-1:0] pulse_addr, next_exp, addr_last;
  logic              sel_prev;
  int                width_cur, width_min, width_max, slips, order_err;
  logic              pulse_live;
  initial begin
    foreach (mem[i]) mem[i] = 8'hff; // erased reads as ones
    foreach (pulses[i]) pulses[i] = 0;
    {width_cur, width_max, slips, order_err} = 0;
    width_min = 32'h7fffffff;
    {pulse_addr, next_exp, addr_last} = '0;
    sel_prev = 1'b0;
  end
  assign pulse_live = pgm && pgm_oe && sel_write;
  always @(posedge clk) begin
    // address must not move under a pulse nor as select/write drops
    if (pulse_live && width_cur > 0 && addr != pulse_addr)
      slips++;
    if (sel_prev && !sel_write && addr != addr_last)
      slips++;
    if (pulse_live) begin
      if (width_cur == 0) begin
        pulse_addr = addr;
        if (addr != 0 && addr != next_exp) order_err++;
      end
      width_cur++;
    end else if (width_cur > 0) begin
      if (addr != pulse_addr) slips++;
      // only zeros are written; a zero never comes back
      mem[pulse_addr] = mem[pulse_addr] & data_in; // binary address
      pulses[pulse_addr]++;
      width_min = (width_cur < width_min) ? width_cur : width_min;
      width_max = (width_cur > width_max) ? width_cur : width_max;
      width_cur = 0;
      next_exp = pulse_addr + 1'b1;
    end
    addr_last = addr;
    sel_prev = sel_write;
  end
endmodule : uvep_eprom_model

// ==== testbench/tb_uv_eprom_program_loop.sv ====
// Purpose: self-checking bench for the eprom loop programmer
// Assumes: short pulse and two loops to keep the run brief
// Notes:   inputs change on the falling edge only
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin \
  errors++; $display("FAIL %s exp %0h got %0h", nm, ex, got); end end
module tb_uv_eprom_program_loop;
  import uvep_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned PW = 10;
  localparam int unsigned LP = 2;
  logic clk, reset, start, large_part, abort_pin, word_req, data_oe;
  logic sel_write_prog, program_pulse, program_pulse_oe, busy, done;
  logic [ADDR_W-1:0] word_req_addr, word_address_lines;
  logic [DATA_W-1:0] word_data, data_out;
  logic [LOOP_W-1:0] loop_index;
  int errors, checks_done, cycles;
  uvep_prog #(.PULSE_CYCLES(PW), .LOOP_COUNT(LP)) u_dut (.clk(clk),
    .reset(reset), .start(start), .large_part(large_part),
    .abort_pin(abort_pin), .word_req(word_req),
    .word_req_addr(word_req_addr), .word_data(word_data),
    .word_address_lines(word_address_lines), .data_out(data_out),
    .data_oe(data_oe), .sel_write_prog(sel_write_prog),
    .program_pulse(program_pulse), .program_pulse_oe(program_pulse_oe),
    .busy(busy), .done(done), .loop_index(loop_index));
  uvep_eprom_model u_eprom (.clk(clk), .addr(word_address_lines),
    .data_in(data_out), .sel_write(sel_write_prog), .pgm(program_pulse),
    .pgm_oe(program_pulse_oe));
  function automatic logic [DATA_W-1:0] pat(input int a);
    return 8'(a) ^ 8'h3c;
  endfunction : pat
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(negedge clk) word_data <= pat(int'(word_req_addr));
  always @(posedge clk) begin
    cycles++;
    if (cycles > 80000) begin
      errors++;
      stop_test();
    end
  end
  task automatic wait_done();
    int n;
    n = 0;
    while (done !== 1'b1 && n < 60000) begin
      @(negedge clk);
      n++;
    end
  endtask : wait_done
  task automatic run_small();
    large_part = 1'b0;
    start = 1'b1;
    @(negedge clk);
    @(negedge clk);
    @(negedge clk);
    `CHK("sel_write_prog", 1'b1, sel_write_prog)
    wait_done();
    `CHK("done", 1'b1, done)
    `CHK("sel_low", 1'b0, sel_write_prog)
    `CHK("pulse_oe", 1'b1, program_pulse_oe)
    `CHK("loop_index", LP - 1, loop_index)
    `CHK("data_oe", 1'b0, data_oe)
    `CHK("width_min", PW, u_eprom.width_min)
    `CHK("width_max", PW, u_eprom.width_max)
    `CHK("slips", 0, u_eprom.slips)
    `CHK("order", 0, u_eprom.order_err)
    for (int a = 0; a < WORDS_LARGE; a++) begin
      `CHK("mem", (a < WORDS_SMALL) ? pat(a) : 8'hff, u_eprom.mem[a])
      `CHK("pulses", (a < WORDS_SMALL) ? LP : 0, u_eprom.pulses[a])
    end
    start = 1'b0;
    repeat (3) @(negedge clk);
    `CHK("busy", 1'b0, busy)
    $display("test run_small done");
  endtask : run_small
  task automatic run_abort();
    int n;
    large_part = 1'b1;
    start = 1'b1;
    n = 0;
    while (word_address_lines !== 10'h203 && n < 40000) begin
      @(negedge clk);
      n++;
    end
    abort_pin = 1'b1;
    wait_done();
    `CHK("abort_done", 1'b1, done)
    `CHK("abort_sel", 1'b0, sel_write_prog)
    `CHK("mem_hi", pat(10'h202), u_eprom.mem[10'h202])
    `CHK("pulse_hi", 1, u_eprom.pulses[10'h202])
    `CHK("pulse_lo", LP + 1, u_eprom.pulses[1])
    `CHK("slips2", 0, u_eprom.slips)
    abort_pin = 1'b0;
    start = 1'b0;
    repeat (3) @(negedge clk);
    $display("test run_abort done");
  endtask : run_abort
  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : stop_test
  initial begin
    {errors, checks_done, cycles} = 0;
    {reset, start, large_part, abort_pin} = 4'b1000;
    word_data = 8'h00;
    repeat (10) @(negedge clk);
    reset = 1'b0;
    run_small();
    run_abort();
    stop_test();
  end
endmodule : tb_uv_eprom_program_loop
